// *** hw/csd_top.v ***
`timescale 1ns/1ns
`default_nettype none
`include "csd_map.vh"
module csd_top (
  input wire core_clk, // Bus clock
  input wire rstn, // Asynchronous reset, active low
  input wire clk_en, // Freezes all state when low
  input wire [2:0] strap_data, // Data lines 7:5 at reset release
  input wire xfer_start, // Transfer address valid this cycle
  input wire xfer_ext, // Transfer comes from external master
  input wire [31:0] xfer_addr, // Transfer address
  input wire xfer_write, // High for write
  input wire [1:0] xfer_size, // Transfer size
  input wire xfer_end, // Transfer done, release selects
  output reg [7:0] select_n, // Active-low selects
  output reg read_enable_n, // Active-low read strobe
  output reg [3:0] byte_lane_strobes_n, // Active-low byte lanes
  output reg [3:0] wait_states, // Wait states of selected region
  output reg int_term, // Internal termination for selected region
  output reg burst_ok, // Selected region allows burst for this direction
  input wire [31:0] s_axi_awaddr, // AXI write address
  input wire s_axi_awvalid, // AXI write address valid
  output reg s_axi_awready, // AXI write address ready
  input wire [31:0] s_axi_wdata, // AXI write data
  input wire [3:0] s_axi_wstrb, // AXI write strobes
  input wire s_axi_wvalid, // AXI write data valid
  output reg s_axi_wready, // AXI write data ready
  output reg [1:0] s_axi_bresp, // AXI write response
  output reg s_axi_bvalid, // AXI write response valid
  input wire s_axi_bready, // AXI write response ready
  input wire [31:0] s_axi_araddr, // AXI read address
  input wire s_axi_arvalid, // AXI read address valid
  output reg s_axi_arready, // AXI read address ready
  output reg [31:0] s_axi_rdata, // AXI read data
  output reg [1:0] s_axi_rresp, // AXI read response
  output reg s_axi_rvalid, // AXI read valid
  input wire s_axi_rready // AXI read ready
);

  reg [31:0] base_reg [0:7];
  reg [31:0] mask_reg [0:7];
  reg [31:0] select_control_reg [0:7];
  reg boot_mode;
  reg strap_done;
  reg [31:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  reg aw_have;
  reg w_have;
  reg rd_pending;
  reg [7:0] match;
  reg [2:0] hit_idx;
  reg hit;
  reg [3:0] next_lanes;
  reg next_read;
  reg sel_read;
  integer i;
  integer j;

  function [31:0] merge;
    input [31:0] old;
    input [31:0] data;
    input [3:0] strb;
    integer k;
    begin
      merge = old;
      for (k = 0; k < 4; k = k + 1)
        if (strb[k])
          merge[k*8 +: 8] = data[k*8 +: 8];
    end
  endfunction

  function regs_ok;
    input [31:0] addr;
    begin
      regs_ok = (addr[7:0] < `CSD_OFF_STATUS) && (addr[3:0] != 4'hC) && (addr[31:8] == 24'h000000);
    end
  endfunction

  // Byte lanes: full port width lanes for 8-bit port or burst, else decoded from size and A1:A0
  function [3:0] lanes;
    input [1:0] sz;
    input [1:0] a;
    input [1:0] ps;
    begin
      if (ps == `CSD_PS_8)
        lanes = 4'h8;
      else if (ps == `CSD_PS_16)
        lanes = (sz == `CSD_SZ_8) ? (a[0] ? 4'h4 : 4'h8) : 4'hC;
      else if (sz == `CSD_SZ_8)
        lanes = 4'h8 >> a;
      else if (sz == `CSD_SZ_16)
        lanes = a[1] ? 4'h3 : 4'hC;
      else
        lanes = 4'hF;
    end
  endfunction

  // Address decode, same path for internal and external masters
  always @*
  begin
    hit = 1'b0;
    hit_idx = 3'h0;
    for (i = 0; i < 8; i = i + 1)
    begin
      match[i] = mask_reg[i][`CSD_MASK_VALID] &&
        (((xfer_addr[31:16] ^ base_reg[i][31:16]) & ~mask_reg[i][31:16]) == 16'h0000);
      if (i == 0 && boot_mode)
        match[i] = 1'b1;
      if (i != 0 && boot_mode)
        match[i] = 1'b0;
    end
    for (i = 7; i >= 0; i = i - 1)
      if (match[i])
      begin
        hit = 1'b1;
        hit_idx = i[2:0];
      end
  end

  always @*
  begin
    next_lanes = lanes(xfer_size, xfer_addr[1:0],
      select_control_reg[hit_idx][`CSD_CTRL_PS_HI:`CSD_CTRL_PS_LO]);
    if (select_control_reg[hit_idx][`CSD_CTRL_BEM] == 1'b0 && !xfer_write)
      next_lanes = 4'h0;
    next_read = hit && !xfer_write;
  end

  // Selects and lanes on the rising edge
  always @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      select_n <= 8'hFF;
      byte_lane_strobes_n <= 4'hF;
      wait_states <= 4'h0;
      int_term <= 1'b0;
      burst_ok <= 1'b0;
      sel_read <= 1'b0;
    end
    else if (clk_en)
    begin
      if (xfer_start && hit)
      begin
        select_n <= ~(8'h01 << hit_idx);
        byte_lane_strobes_n <= ~next_lanes;
        wait_states <= select_control_reg[hit_idx][`CSD_CTRL_WS_HI:`CSD_CTRL_WS_LO];
        int_term <= select_control_reg[hit_idx][`CSD_CTRL_AA];
        burst_ok <= xfer_write ? select_control_reg[hit_idx][`CSD_CTRL_BSTW] :
          select_control_reg[hit_idx][`CSD_CTRL_BSTR];
        sel_read <= next_read;
      end
      else if (xfer_end || xfer_start)
      begin
        select_n <= 8'hFF;
        byte_lane_strobes_n <= 4'hF;
        sel_read <= 1'b0;
      end
    end
  end

  // Read strobe flop on the falling edge, fed from rising-edge select state
  always @(negedge core_clk or negedge rstn)
  begin
    if (!rstn)
      read_enable_n <= 1'b1;
    else if (clk_en)
      read_enable_n <= ~sel_read;
  end

  // Boot select: strap sampled at first enabled edge after release
  always @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      strap_done <= 1'b0;
      boot_mode <= 1'b1;
    end
    else if (clk_en)
    begin
      strap_done <= 1'b1;
      if (s_axi_wready && s_axi_wvalid && aw_have && aw_addr[7:0] == {4'h0, `CSD_OFF_MASK})
        boot_mode <= 1'b0;
      else if (s_axi_wvalid && s_axi_awvalid && !aw_have && !w_have && s_axi_awaddr[7:0] == {4'h0, `CSD_OFF_MASK})
        boot_mode <= 1'b0;
    end
  end

  // AXI4-Lite slave
  always @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `CSD_RESP_OKAY;
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `CSD_RESP_OKAY;
      s_axi_rdata <= 32'h00000000;
      aw_have <= 1'b0;
      w_have <= 1'b0;
      aw_addr <= 32'h00000000;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      rd_pending <= 1'b0;
      for (j = 0; j < 8; j = j + 1)
      begin
        base_reg[j] <= `CSD_BASE_RST;
        mask_reg[j] <= `CSD_MASK_RST;
        select_control_reg[j] <= `CSD_CTRL_RST;
      end
    end
    else if (clk_en)
    begin
      if (!strap_done)
      begin
        select_control_reg[0][`CSD_CTRL_PS_HI:`CSD_CTRL_PS_LO] <= strap_data[2:1];
        select_control_reg[0][`CSD_CTRL_AA] <= strap_data[0];
        select_control_reg[0][`CSD_CTRL_BEM] <= strap_data[0];
      end
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_addr <= s_axi_awaddr;
        aw_have <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        w_have <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (aw_have && w_have && !s_axi_bvalid)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= regs_ok(aw_addr) ? `CSD_RESP_OKAY : `CSD_RESP_SLVERR;
        if (regs_ok(aw_addr))
        begin
          case (aw_addr[3:0])
            `CSD_OFF_BASE: base_reg[aw_addr[6:4]] <= merge(base_reg[aw_addr[6:4]], w_data, w_strb);
            `CSD_OFF_MASK: mask_reg[aw_addr[6:4]] <= merge(mask_reg[aw_addr[6:4]], w_data, w_strb);
            `CSD_OFF_CTRL: select_control_reg[aw_addr[6:4]] <=
              merge(select_control_reg[aw_addr[6:4]], w_data, w_strb);
            default: ;
          endcase
        end
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        aw_have <= 1'b0;
        w_have <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `CSD_RESP_OKAY;
        if (s_axi_araddr[7:0] == `CSD_OFF_STATUS && s_axi_araddr[31:8] == 24'h000000)
          s_axi_rdata <= {22'h000000, boot_mode, ~read_enable_n, ~select_n};
        else if (!regs_ok(s_axi_araddr))
        begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `CSD_RESP_SLVERR;
        end
        else if (s_axi_araddr[3:0] == `CSD_OFF_BASE)
          s_axi_rdata <= base_reg[s_axi_araddr[6:4]];
        else if (s_axi_araddr[3:0] == `CSD_OFF_MASK)
          s_axi_rdata <= mask_reg[s_axi_araddr[6:4]];
        else
          s_axi_rdata <= select_control_reg[s_axi_araddr[6:4]];
      end
      if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule // csd_top
`default_nettype wire

// *** shared/csd_map.vh ***
`ifndef CSD_MAP_VH
`define CSD_MAP_VH
// Register byte offsets: per select n, base at 0x00+16n, mask at 0x04+16n, control at 0x08+16n
`define CSD_REG_STRIDE 8'h10
`define CSD_OFF_BASE 4'h0
`define CSD_OFF_MASK 4'h4
`define CSD_OFF_CTRL 4'h8
`define CSD_OFF_STATUS 8'h80
// Mask register: bits 31:16 mask address bits, bit 0 valid
`define CSD_MASK_VALID 0
// Control register fields
`define CSD_CTRL_WS_HI 13
`define CSD_CTRL_WS_LO 10
`define CSD_CTRL_AA 8
`define CSD_CTRL_PS_HI 7
`define CSD_CTRL_PS_LO 6
`define CSD_CTRL_BEM 5
`define CSD_CTRL_BSTR 4
`define CSD_CTRL_BSTW 3
// Port size encodings
`define CSD_PS_32 2'h0
`define CSD_PS_8 2'h1
`define CSD_PS_16 2'h2
// Transfer size encodings
`define CSD_SZ_32 2'h0
`define CSD_SZ_8 2'h1
`define CSD_SZ_16 2'h2
`define CSD_SZ_LINE 2'h3
// Reset values and AXI response codes
`define CSD_CTRL_RST 32'h00003C00
`define CSD_MASK_RST 32'h00000000
`define CSD_BASE_RST 32'h00000000
`define CSD_RESP_OKAY 2'h0
`define CSD_RESP_SLVERR 2'h2
`endif

// *** sim/csd_chk.sv ***
`timescale 1ns/1ns
`default_nettype none
module csd_chk (
  input wire core_clk, // Clock
  input wire rstn, // Reset
  input wire clk_en, // Enable
  input wire xfer_start, // Start
  input wire xfer_ext, // External
  input wire xfer_write, // Write
  input wire [1:0] xfer_size, // Size
  input wire xfer_end, // End
  input wire s_axi_awvalid, // Write address valid
  input wire s_axi_awready, // Write address ready
  input wire [7:0] select_n, // Selects
  input wire read_enable_n, // Read strobe
  input wire [3:0] byte_lane_strobes_n // Lanes
);
  reg cfg;
  reg re_pos;
  // Boot checks assume straps of 32-bit port and write-only lanes
  wire go = xfer_start && clk_en && !cfg;
  always @(posedge core_clk or negedge rstn)
    if (!rstn)
      cfg <= 1'b0;
    else if (s_axi_awvalid && s_axi_awready)
      cfg <= 1'b1;
  always @(posedge core_clk)
    re_pos <= read_enable_n;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  sequence rel_s;
    select_n == 8'hFF ##1 read_enable_n;
  endsequence
  idle_upper_a: assert property (!cfg |-> select_n[7:1] == 7'h7F) else $error("upper select active");
  boot_hit_a: assert property (go && !xfer_ext |=> !select_n[0]) else $error("boot select missed");
  ext_hit_a: assert property (go && xfer_ext |=> !select_n[0]) else $error("external miss");
  one_select_a: assert property ($onehot0(~select_n)) else $error("two selects");
  read_match_a: assert property (!read_enable_n |-> select_n != 8'hFF) else $error("strobe no match");
  release_a: assert property (xfer_end && clk_en && !xfer_start |=> rel_s) else $error("no release");
  re_fall_a: assert property (@(negedge core_clk) read_enable_n == re_pos) else $error("strobe on rise");
  read_lanes_a: assert property (go && !xfer_write |=> byte_lane_strobes_n == 4'hF) else $error("read lanes");
  long_write_a: assert property (go && xfer_write && xfer_size == 2'h0 |=> byte_lane_strobes_n == 4'h0)
    else $error("write lanes");
endmodule // csd_chk
bind csd_top csd_chk chk_u (
  .core_clk(core_clk), .rstn(rstn), .clk_en(clk_en), .xfer_start(xfer_start), .xfer_ext(xfer_ext),
  .xfer_write(xfer_write), .xfer_size(xfer_size), .xfer_end(xfer_end), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .select_n(select_n), .read_enable_n(read_enable_n),
  .byte_lane_strobes_n(byte_lane_strobes_n)
);
`default_nettype wire

// *** sim/csd_mem.sv ***
`timescale 1ns/1ns
`default_nettype none
module csd_mem #(parameter [2:0] STRAP = 3'h0) (
  input wire core_clk, // Bus clock
  input wire rstn, // Reset, active low
  input wire [7:0] select_n, // Selects from the block
  output wire [2:0] strap_data, // Boot straps
  output reg xfer_end // Cycle termination
);
  // Straps stay constant so they are stable across the release edge
  assign strap_data = STRAP;
  // Ends each selected cycle after one clock, like a zero-wait memory
  always @(posedge core_clk or negedge rstn)
    if (!rstn)
      xfer_end <= 1'b0;
    else
      xfer_end <= (select_n != 8'hFF) && !xfer_end;
endmodule // csd_mem
`default_nettype wire

// *** sim/testbench.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "csd_map.vh"
module testbench;
  reg core_clk, rstn, clk_en, xfer_start, xfer_ext, xfer_write, s_axi_awvalid, s_axi_wvalid;
  reg s_axi_bready, s_axi_arvalid, s_axi_rready;
  reg [31:0] xfer_addr, s_axi_awaddr, s_axi_wdata, s_axi_araddr, seed, d;
  reg [1:0] xfer_size, r;
  reg [3:0] s_axi_wstrb;
  wire [7:0] select_n;
  wire [3:0] byte_lane_strobes_n, wait_states;
  wire [2:0] strap_data;
  wire read_enable_n, xfer_end, int_term, burst_ok, s_axi_awready, s_axi_wready, s_axi_bvalid;
  wire s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  integer fail_count, compares, i;
  csd_top dut_u (
    .core_clk(core_clk), .rstn(rstn), .clk_en(clk_en), .strap_data(strap_data), .xfer_start(xfer_start),
    .xfer_ext(xfer_ext), .xfer_addr(xfer_addr), .xfer_write(xfer_write), .xfer_size(xfer_size),
    .xfer_end(xfer_end), .select_n(select_n), .read_enable_n(read_enable_n),
    .byte_lane_strobes_n(byte_lane_strobes_n), .wait_states(wait_states), .int_term(int_term),
    .burst_ok(burst_ok), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
  );
  csd_mem mem_u (
    .core_clk(core_clk), .rstn(rstn), .select_n(select_n), .strap_data(strap_data), .xfer_end(xfer_end)
  );
  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  function [31:0] nx;
    begin
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      nx = seed;
    end
  endfunction
  function [3:0] ln(input [1:0] sz, input [1:0] a, input [1:0] ps, input w, input b);
    reg [3:0] p;
    begin
      if (ps == `CSD_PS_16)
        p = (sz == `CSD_SZ_8) ? (a[0] ? 4'h4 : 4'h8) : 4'hC;
      else
        p = (sz == `CSD_SZ_8) ? (4'h8 >> a) : (sz == `CSD_SZ_16) ? (a[1] ? 4'h3 : 4'hC) : 4'hF;
      ln = (w | b) ? ~p : 4'hF;
    end
  endfunction
  task chk(input [31:0] g, input [31:0] e);
    begin
      compares = compares + 1;
      if (g !== e)
      begin
        fail_count = fail_count + 1;
        $display("Error at %0t: got %h expected %h", $time, g, e);
      end
    end
  endtask
  task wr(input [31:0] a, input [31:0] v);
    begin
      @(posedge core_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
        @(posedge core_clk);
        if (s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end
      while (!s_axi_bvalid);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
    end
  endtask
  task rd(input [31:0] a);
    begin
      @(posedge core_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
        @(posedge core_clk);
        if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end
      while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
    end
  endtask
  task xf(input [31:0] a, input w, input [1:0] sz, input [7:0] es, input [1:0] ps, input b);
    integer n;
    begin
      @(posedge core_clk);
      xfer_addr <= a;
      xfer_write <= w;
      xfer_size <= sz;
      xfer_ext <= a[4];
      xfer_start <= 1'b1;
      @(posedge core_clk);
      xfer_start <= 1'b0;
      @(negedge core_clk);
      chk(select_n, es);
      chk(byte_lane_strobes_n, ln(sz, a[1:0], ps, w, b));
      // Read strobe follows the select by half a cycle
      @(posedge core_clk);
      chk(read_enable_n, (es == 8'hFF) | w);
      for (n = 0; n < 8 && select_n != 8'hFF; n = n + 1) @(posedge core_clk);
      @(negedge core_clk);
    end
  endtask
  task summarize;
    begin
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  initial
  begin
    #1000000;
    fail_count = fail_count + 1;
    summarize;
  end
  initial
  begin
    {rstn, xfer_start, xfer_ext, xfer_write, s_axi_awvalid, s_axi_wvalid} = 6'h00;
    {s_axi_bready, s_axi_arvalid, s_axi_rready, clk_en} = 4'h1;
    {xfer_addr, s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 128'h0;
    xfer_size = 2'h0;
    s_axi_wstrb = 4'hF;
    seed = 32'h0001481B;
    fail_count = 0;
    compares = 0;
    repeat (5) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    for (i = 0; i < 40; i = i + 1)
    begin
      d = nx();
      xf(d, d[8], d[10:9], 8'hFE, `CSD_PS_32, 1'b0);
      chk({wait_states, int_term, burst_ok}, {4'hF, 1'b0, 1'b0});
    end
    $display("test boot done");
    wr(32'h04, 32'h0);
    chk(r, `CSD_RESP_OKAY);
    wr(32'h10, 32'h12340000);
    wr(32'h14, 32'h00000001);
    wr(32'h18, 32'h000015B0);
    wr(32'h24, 32'hFFFF0001);
    rd(32'h18);
    chk(d, 32'h000015B0);
    rd(32'h38);
    chk(d, `CSD_CTRL_RST);
    rd(32'h90);
    chk(r, `CSD_RESP_SLVERR);
    for (i = 0; i < 30; i = i + 1)
    begin
      d = nx();
      // Odd steps keep clear of region one so the catch-all region answers
      xf(i[0] ? {d[31:16] ^ {15'h0000, d[31:16] == 16'h1234}, d[15:0]} : {16'h1234, d[15:0]}, d[8], d[10:9],
        i[0] ? 8'hFB : 8'hFD, i[0] ? `CSD_PS_32 : `CSD_PS_16, !i[0]);
      chk({wait_states, int_term, burst_ok}, i[0] ? 6'h3C : {4'h5, 1'b1, !d[8]});
    end
    xf(32'h1234FFFF, 1'b0, `CSD_SZ_8, 8'hFD, `CSD_PS_16, 1'b1);
    wr(32'h24, 32'h0);
    xf(32'h12350000, 1'b0, `CSD_SZ_32, 8'hFF, `CSD_PS_32, 1'b0);
    wr(32'h9C, 32'h00000001);
    chk(r, `CSD_RESP_SLVERR);
    rd(32'h80);
    chk(d, 32'h00000000);
    // Frozen block must ignore a matching transfer
    clk_en <= 1'b0;
    xf(32'h12340000, 1'b0, `CSD_SZ_32, 8'hFF, `CSD_PS_16, 1'b0);
    clk_en <= 1'b1;
    $display("test regions done");
    summarize;
  end
endmodule // testbench
`default_nettype wire
